// file: hdl/apm_power_mgr.sv
// Auto power management for floppy, two UART channels and parallel port
// ****************************************************************
// Notes on behaviour
// ****************************************************************
// Notes on behaviour
// (R1) Status, control, rate and config accesses don't wake
// (R2) Main status read or data access wakes
// (R3) Motor enable or software reset wakes floppy
// (R4) System pins live; irq and dma held low
// (R5) Motor, select, write data, gate tristated asleep
// (R6) Step, direction, side, density stay driven
// (R7) Direct powerdown per function from config
// (R8) UART auto powerdown gated by bits four, five
// (R9) Transmitter sleeps when buffer and shifter empty
// (R10) Receiver sleeps when fifo empty and idle
// (R11) Ring interrupt follows bell input while asleep
// (R12) Transmit write or rx edge wakes UART
// (R13) Parallel auto powerdown gated by bit three
// (R14) EPP sleeps unless enabled and selected
// (R15) ECP sleeps unless enabled and ECP mode
// (R16) Parallel power re-evaluated on mode change
// (R17) Floppy sleeps: motors off, idle, timers expired
// (R18) Wake resumes state and restarts idle timer
// (R19) Clearing bit zero cancels timer, holds awake
// (R20) Sleeping accesses keep true status and writes
// (R21) Wake sources synchronised before clearing powerdown; the transmit write wake is not synchronised
`timescale 1ns/1ps
`include "apm_params.svh"

module apm_power_mgr
(
	input wire logic clk,
	input wire logic rst,
	input wire apm_pkg::apm_host_acc_t host_acc,
	output logic [7:0] host_rdata,
	input wire logic [7:0] status_a_in,
	input wire logic [7:0] status_b_in,
	input wire logic [7:0] main_status_in,
	input wire logic [7:0] data_fifo_in,
	input wire logic [7:0] disk_input_in,
	input wire logic fdc_int_in,
	input wire logic head_unload_expired,
	input wire logic fdc_irq_core,
	input wire logic fdc_drq_core,
	output logic interrupt_req_out,
	output logic dma_req_out,
	input wire apm_pkg::apm_fdd_pins_t fdd_core,
	output apm_pkg::apm_fdd_pins_t fdd_out,
	output apm_pkg::apm_fdd_oe_t fdd_oe,
	output logic [7:0] drive_output_ctrl,
	output logic [7:0] rate_select_reg,
	output logic [7:0] rate_config_ctrl,
	input wire logic [7:0] direct_powerdown_cfg,
	input wire logic [7:0] auto_powerdown_cfg,
	input wire apm_pkg::apm_uart_stat_t uart0,
	input wire apm_pkg::apm_uart_stat_t uart1,
	input wire logic [1:0] tx_buf_write,
	output logic [1:0] uart_tx_pd,
	output logic [1:0] uart_rx_pd,
	output logic [1:0] uart_ri_int,
	input wire apm_pkg::apm_par_cfg_t par_cfg,
	output logic epp_pd,
	output logic ecp_pd,
	output logic fdc_pd
);

	localparam logic [20:0] IDLE_LAST = 21'(`APM_IDLE_CYCLES - 1);

	apm_pkg::apm_state_t st;
	apm_pkg::apm_state_t next_st;

	// ****************************************************************
	// Access decode
	// ****************************************************************
	function automatic logic is_wake_access(input apm_pkg::apm_host_acc_t a);
		logic w;
		w = 1'b0;
		if (a.rd && a.addr == `APM_OFS_MAIN_STAT)
			w = 1'b1; // R2
		if ((a.rd || a.wr) && a.addr == `APM_OFS_DATA)
			w = 1'b1; // R2
		if (a.wr && a.addr == `APM_OFS_DRIVE_OUT)
		begin
			if (a.wdata[`APM_DOR_MOTOR_LO+:4] != 4'h0 || !a.wdata[`APM_DOR_RESET_N])
				w = 1'b1; // R3
		end
		if (a.wr && a.addr == `APM_OFS_RATE_SEL && a.wdata[`APM_DSR_SWRESET])
			w = 1'b1; // R3
		return w; // R1
	endfunction

	// Sleep decision for one UART direction
	function automatic logic uart_sleep(input logic en, input logic idle, input logic wake);
		return en && idle && !wake;
	endfunction

	logic fdc_asleep;
	logic fdc_idle;
	logic auto_fdc_en;
	logic [4:0] par_mode_now;

	assign fdc_asleep = st.fdc_state == apm_pkg::APM_FDC_ASLEEP;
	assign auto_fdc_en = auto_powerdown_cfg[`APM_CFG_FDC];
	assign fdc_idle = st.drive_output_ctrl[`APM_DOR_MOTOR_LO+:4] == 4'h0
		&& main_status_in == `APM_MSR_IDLE && !fdc_int_in && head_unload_expired; // R17
	assign par_mode_now = {par_cfg.epp_enabled, par_cfg.ecp_enabled, par_cfg.ecr_mode};

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		next_st = st;
		// Access and rx wake flags pass a two-stage synchroniser first
		next_st.acc_sync = {st.acc_sync[0], is_wake_access(host_acc)}; // R21
		next_st.rx0_sync = {st.rx0_sync[0], uart0.serial_rx_in}; // R21
		next_st.rx1_sync = {st.rx1_sync[0], uart1.serial_rx_in}; // R21
		next_st.rx0_last = st.rx0_sync[1];
		next_st.rx1_last = st.rx1_sync[1];
		next_st.rx0_wake = st.rx0_sync[1] != st.rx0_last; // R12
		next_st.rx1_wake = st.rx1_sync[1] != st.rx1_last; // R12

		// Writes are kept even while asleep
		if (host_acc.wr)
		begin
			unique case (host_acc.addr)
				`APM_OFS_DRIVE_OUT: next_st.drive_output_ctrl = host_acc.wdata; // R20
				`APM_OFS_RATE_SEL: next_st.rate_select = host_acc.wdata; // R20
				`APM_OFS_RATE_CFG: next_st.rate_config = host_acc.wdata; // R20
				default: ;
			endcase
		end

		if (!auto_fdc_en)
		begin
			next_st.fdc_state = apm_pkg::APM_FDC_AWAKE; // R19
			next_st.idle_cnt = '0; // R19
		end
		else
		begin
			unique case (st.fdc_state)
				apm_pkg::APM_FDC_AWAKE:
				begin
					next_st.idle_cnt = '0;
					next_st.fdc_state = apm_pkg::APM_FDC_COUNT;
				end
				apm_pkg::APM_FDC_COUNT:
				begin
					if (st.acc_sync[1])
						next_st.idle_cnt = '0; // R18
					else if (st.idle_cnt != IDLE_LAST)
						next_st.idle_cnt = st.idle_cnt + 21'h1;
					else if (fdc_idle)
						next_st.fdc_state = apm_pkg::APM_FDC_ASLEEP; // R17
				end
				apm_pkg::APM_FDC_ASLEEP:
				begin
					if (st.acc_sync[1])
					begin
						next_st.fdc_state = apm_pkg::APM_FDC_COUNT; // R18
						next_st.idle_cnt = '0; // R18
					end
				end
			endcase
		end

		// UART channels
		next_st.tx_pd[0] = uart_sleep(auto_powerdown_cfg[`APM_CFG_UART0],
			uart0.thr_empty && uart0.tsr_empty, tx_buf_write[0]); // R8 R9 R12
		next_st.tx_pd[1] = uart_sleep(auto_powerdown_cfg[`APM_CFG_UART1],
			uart1.thr_empty && uart1.tsr_empty, tx_buf_write[1]); // R8 R9 R12
		next_st.rx_pd[0] = uart_sleep(auto_powerdown_cfg[`APM_CFG_UART0],
			uart0.rx_fifo_empty && uart0.rx_idle, st.rx0_wake); // R8 R10 R12
		next_st.rx_pd[1] = uart_sleep(auto_powerdown_cfg[`APM_CFG_UART1],
			uart1.rx_fifo_empty && uart1.rx_idle, st.rx1_wake); // R8 R10 R12
		// Ring interrupt never gated by powerdown
		next_st.ri_int = {uart1.ri_int, uart0.ri_int}; // R11

		// Parallel port evaluated when a mode input moves or the auto bit turns on
		next_st.par_mode_last = par_mode_now;
		next_st.par_eval = par_mode_now != st.par_mode_last
			|| auto_powerdown_cfg[`APM_CFG_PAR] != (st.epp_pd || st.ecp_pd || st.par_eval); // R16
		if (!auto_powerdown_cfg[`APM_CFG_PAR])
		begin
			next_st.epp_pd = 1'b0; // R13
			next_st.ecp_pd = 1'b0; // R13
		end
		else if (st.par_eval || par_mode_now != st.par_mode_last)
		begin
			next_st.epp_pd = !par_cfg.epp_enabled
				|| (par_cfg.ecp_enabled && par_cfg.ecr_mode != `APM_ECR_EPP); // R14
			next_st.ecp_pd = !par_cfg.ecp_enabled || par_cfg.ecr_mode == `APM_ECR_SPP
				|| par_cfg.ecr_mode == `APM_ECR_BIDIR
				|| par_cfg.ecr_mode == `APM_ECR_EPP; // R15
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st <= '0;
			st.fdc_state <= apm_pkg::APM_FDC_AWAKE;
			st.drive_output_ctrl <= 8'h04;
			st.par_eval <= 1'b1;
			// Serial lines idle high, so no false rx edge right after reset
			st.rx0_sync <= 2'h3;
			st.rx1_sync <= 2'h3;
			st.rx0_last <= 1'b1;
			st.rx1_last <= 1'b1;
		end
		else
			st <= next_st;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	logic fdc_off;
	assign fdc_off = fdc_asleep || direct_powerdown_cfg[`APM_DIRECT_FDC]; // R7
	assign fdc_pd = fdc_off;

	// Sleeping reads still show live status
	always_comb
	begin
		unique case (host_acc.addr)
			`APM_OFS_STATUS_A: host_rdata = status_a_in; // R20
			`APM_OFS_STATUS_B: host_rdata = status_b_in; // R20
			`APM_OFS_DRIVE_OUT: host_rdata = st.drive_output_ctrl; // R20
			`APM_OFS_MAIN_STAT: host_rdata = main_status_in;
			`APM_OFS_DATA: host_rdata = data_fifo_in;
			`APM_OFS_DISK_IN: host_rdata = disk_input_in; // R20
			default: host_rdata = 8'h00;
		endcase
	end

	assign interrupt_req_out = fdc_irq_core && !fdc_off; // R4
	assign dma_req_out = fdc_drq_core && !fdc_off; // R4

	// Motor, select and write lines to the drive float so no current flows into it
	always_comb
	begin
		fdd_out = fdd_core; // R6
		fdd_oe.motor_on = {2{!fdc_off}}; // R5
		fdd_oe.drive_select = {2{!fdc_off}}; // R5
		fdd_oe.write_stream = !fdc_off; // R5
		fdd_oe.write_gate = !fdc_off; // R5
	end

	assign drive_output_ctrl = st.drive_output_ctrl;
	assign rate_select_reg = st.rate_select;
	assign rate_config_ctrl = st.rate_config;
	assign uart_tx_pd = st.tx_pd | {direct_powerdown_cfg[`APM_DIRECT_UART1],
		direct_powerdown_cfg[`APM_DIRECT_UART0]}; // R7
	assign uart_rx_pd = st.rx_pd | {direct_powerdown_cfg[`APM_DIRECT_UART1],
		direct_powerdown_cfg[`APM_DIRECT_UART0]}; // R7
	assign uart_ri_int = st.ri_int;
	assign epp_pd = st.epp_pd || direct_powerdown_cfg[`APM_DIRECT_PAR]; // R7
	assign ecp_pd = st.ecp_pd || direct_powerdown_cfg[`APM_DIRECT_PAR]; // R7

endmodule

// file: hdl/apm_params.svh
// Constants for the auto power management block: offsets, fields, timings
`ifndef APM_PARAMS_SVH
`define APM_PARAMS_SVH

// Floppy register offsets from the base
`define APM_OFS_STATUS_A 3'h0
`define APM_OFS_STATUS_B 3'h1
`define APM_OFS_DRIVE_OUT 3'h2
`define APM_OFS_RATE_SEL 3'h4
`define APM_OFS_MAIN_STAT 3'h4
`define APM_OFS_DATA 3'h5
`define APM_OFS_DISK_IN 3'h7
`define APM_OFS_RATE_CFG 3'h7

// Field positions
`define APM_DOR_RESET_N 2
`define APM_DOR_MOTOR_LO 4
`define APM_DSR_SWRESET 7
`define APM_CFG_FDC 0
`define APM_CFG_PAR 3
`define APM_CFG_UART0 4
`define APM_CFG_UART1 5
`define APM_DIRECT_FDC 0
`define APM_DIRECT_PAR 3
`define APM_DIRECT_UART0 4
`define APM_DIRECT_UART1 5

// Main status idle value
`define APM_MSR_IDLE 8'h80

// Extended port control mode codes
`define APM_ECR_SPP 3'h0
`define APM_ECR_BIDIR 3'h1
`define APM_ECR_EPP 3'h4

// Idle timer: 10 ms at 125 MHz
`define APM_IDLE_TIME_MS 10
`define APM_CLK_MHZ 125
`define APM_IDLE_CYCLES (`APM_IDLE_TIME_MS * `APM_CLK_MHZ * 1000)

`endif

// file: hdl/apm_pkg.sv
// Types for the auto power management block
package apm_pkg;

	typedef enum logic [1:0] {
		APM_FDC_AWAKE,
		APM_FDC_COUNT,
		APM_FDC_ASLEEP
	} apm_fdc_state_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} apm_host_acc_t;

	typedef struct packed {
		logic [1:0] motor_on;
		logic [1:0] drive_select;
		logic write_stream;
		logic write_gate;
		logic seek_sense;
		logic step;
		logic head_side;
		logic [1:0] density;
	} apm_fdd_pins_t;

	typedef struct packed {
		logic [1:0] motor_on;
		logic [1:0] drive_select;
		logic write_stream;
		logic write_gate;
	} apm_fdd_oe_t;

	typedef struct packed {
		logic thr_empty;
		logic tsr_empty;
		logic rx_fifo_empty;
		logic rx_idle;
		logic serial_rx_in;
		logic modem_bell_in;
		logic ri_int;
	} apm_uart_stat_t;

	typedef struct packed {
		logic epp_enabled;
		logic ecp_enabled;
		logic [2:0] ecr_mode;
	} apm_par_cfg_t;

	typedef struct packed {
		apm_fdc_state_t fdc_state;
		logic [20:0] idle_cnt;
		logic [7:0] drive_output_ctrl;
		logic [7:0] rate_select;
		logic [7:0] rate_config;
		logic [1:0] acc_sync;
		logic [1:0] rx0_sync;
		logic [1:0] rx1_sync;
		logic rx0_last;
		logic rx1_last;
		logic rx0_wake;
		logic rx1_wake;
		logic [1:0] tx_pd;
		logic [1:0] rx_pd;
		logic [1:0] ri_int;
		logic epp_pd;
		logic ecp_pd;
		logic [4:0] par_mode_last;
		logic par_eval;
	} apm_state_t;

endpackage

// file: test/apm_power_mgr_props.sv
// Checker of the power management ports
`timescale 1ns/1ps
module apm_power_mgr_props
(
	input wire logic clk,
	input wire logic rst,
	input wire apm_pkg::apm_host_acc_t host_acc,
	input wire logic [7:0] host_rdata,
	input wire logic [7:0] status_a_in,
	input wire logic fdc_irq_core,
	input wire logic fdc_drq_core,
	input wire logic interrupt_req_out,
	input wire logic dma_req_out,
	input wire apm_pkg::apm_fdd_oe_t fdd_oe,
	input wire logic [7:0] direct_powerdown_cfg,
	input wire logic [7:0] auto_powerdown_cfg,
	input wire apm_pkg::apm_uart_stat_t uart0,
	input wire apm_pkg::apm_uart_stat_t uart1,
	input wire logic [1:0] tx_buf_write,
	input wire logic [1:0] uart_tx_pd,
	input wire logic [1:0] uart_ri_int,
	input wire apm_pkg::apm_par_cfg_t par_cfg,
	input wire logic ecp_pd,
	input wire logic fdc_pd
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// ****
	// Assertions
	// ****
	irq_gated_a: assert property (interrupt_req_out == (fdc_irq_core && !fdc_pd))
		else $error("irq not gated");
	drq_gated_a: assert property (dma_req_out == (fdc_drq_core && !fdc_pd))
		else $error("drq not gated");
	drive_tristate_a: assert property (fdd_oe == {6{!fdc_pd}})
		else $error("drive enables wrong");
	direct_fdc_a: assert property (direct_powerdown_cfg[0] |-> fdc_pd)
		else $error("direct floppy powerdown ignored");
	data_wake_a: assert property (fdc_pd && !direct_powerdown_cfg[0] && host_acc.rd &&
		host_acc.addr == 3'h5 |-> ##3 (!fdc_pd || direct_powerdown_cfg[0]))
		else $error("data read did not wake");
	status_true_a: assert property (host_acc.addr == 3'h0 |-> host_rdata == status_a_in)
		else $error("status read wrong");
	tx_disabled_a: assert property ((!auto_powerdown_cfg[4] && !direct_powerdown_cfg[4])[*2]
		|-> !uart_tx_pd[0])
		else $error("tx slept while disabled");
	tx_sleep_a: assert property ((auto_powerdown_cfg[4] && uart0.thr_empty && uart0.tsr_empty
		&& !tx_buf_write[0])[*2] |-> uart_tx_pd[0])
		else $error("idle tx not asleep");
	ecp_sleep_a: assert property ((auto_powerdown_cfg[3] && !par_cfg.ecp_enabled)[*3] |-> ecp_pd)
		else $error("disabled ecp awake");
	ring_follow_a: assert property ($past(rst) || uart_ri_int == $past({uart1.ri_int, uart0.ri_int}))
		else $error("ring interrupt lost");
	cover property ($rose(uart_tx_pd[0]));
	cover property ($fell(uart_tx_pd[0]));
	cover property ($rose(ecp_pd));
endmodule
bind apm_power_mgr apm_power_mgr_props u_props (.clk(clk), .rst(rst), .host_acc(host_acc),
	.host_rdata(host_rdata), .status_a_in(status_a_in), .fdc_irq_core(fdc_irq_core),
	.fdc_drq_core(fdc_drq_core), .interrupt_req_out(interrupt_req_out),
	.dma_req_out(dma_req_out), .fdd_oe(fdd_oe), .direct_powerdown_cfg(direct_powerdown_cfg),
	.auto_powerdown_cfg(auto_powerdown_cfg), .uart0(uart0), .uart1(uart1),
	.tx_buf_write(tx_buf_write), .uart_tx_pd(uart_tx_pd), .uart_ri_int(uart_ri_int),
	.par_cfg(par_cfg), .ecp_pd(ecp_pd), .fdc_pd(fdc_pd));

// file: test/apm_uart_model.sv
// Behavioural UART channel feeding status to the power manager
`timescale 1ns/1ps
module apm_uart_model
(
	input wire logic clk,
	input wire logic rst,
	input wire logic wr,
	input wire logic rx,
	input wire logic bell,
	output apm_pkg::apm_uart_stat_t st
);
	logic [2:0] busy;
	// Holding buffer empties before the shifter, as a real channel does
	always_ff @(posedge clk or posedge rst)
		if (rst)
			busy <= 3'h0;
		else if (wr)
			busy <= 3'h4;
		else if (busy != 3'h0)
			busy <= busy - 3'h1;
	assign st = '{thr_empty: !wr && busy < 3'h3, tsr_empty: !wr && busy == 3'h0,
		rx_fifo_empty: 1'b1, rx_idle: rx, serial_rx_in: rx, modem_bell_in: bell, ri_int: bell};
endmodule

// file: test/test_auto_power_management.sv
// Testbench of the auto power management block
`timescale 1ns/1ps
module test_auto_power_management;
	logic clk = 1'b0, rst = 1'b1, irq = 1'b0, drq = 1'b0;
	logic [7:0] sv = 8'h00, dcfg = 8'h00, acfg = 8'h00, rd, doc, rsr, rcc;
	logic [1:0] txw = 2'h0, rxl = 2'h3, bell = 2'h0, txp, rxp, rii;
	logic iro, dro, ep, ec, fp;
	apm_pkg::apm_host_acc_t acc = '0;
	apm_pkg::apm_fdd_pins_t core = '0, fo;
	apm_pkg::apm_fdd_oe_t oe;
	apm_pkg::apm_uart_stat_t u0, u1;
	apm_pkg::apm_par_cfg_t pc = '0;
	int fail_count = 0, cmp_count = 0;
	// {epp_en, ecp_en, mode, epp_pd, ecp_pd}
	logic [6:0] rows [8] = '{7'h03, 7'h41, 7'h33, 7'h71, 7'h23, 7'h27, 7'h2e, 7'h6e};
	apm_power_mgr uut (.clk(clk), .rst(rst), .host_acc(acc), .host_rdata(rd),
		.status_a_in(sv), .status_b_in(sv), .main_status_in(sv), .data_fifo_in(sv),
		.disk_input_in(sv), .fdc_int_in(1'b0), .head_unload_expired(1'b1),
		.fdc_irq_core(irq), .fdc_drq_core(drq), .interrupt_req_out(iro), .dma_req_out(dro),
		.fdd_core(core), .fdd_out(fo), .fdd_oe(oe), .drive_output_ctrl(doc),
		.rate_select_reg(rsr), .rate_config_ctrl(rcc), .direct_powerdown_cfg(dcfg),
		.auto_powerdown_cfg(acfg), .uart0(u0), .uart1(u1), .tx_buf_write(txw),
		.uart_tx_pd(txp), .uart_rx_pd(rxp), .uart_ri_int(rii), .par_cfg(pc), .epp_pd(ep),
		.ecp_pd(ec), .fdc_pd(fp));
	apm_uart_model m0 (.clk(clk), .rst(rst), .wr(txw[0]), .rx(rxl[0]), .bell(bell[0]), .st(u0));
	apm_uart_model m1 (.clk(clk), .rst(rst), .wr(txw[1]), .rx(rxl[1]), .bell(bell[1]), .st(u1));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// Checks land 1 ns after the edge so registered outputs have settled
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic final_report();
		if (fail_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
		forever #4 clk = ~clk;
	initial
	begin
		repeat (5000) @(posedge clk);
		fail_count++;
		final_report();
	end
	initial
	begin
		wt(9);
		chk(doc, 8'h04);
		chk({fp, ep, ec, txp, rxp}, 16'h0000);
		chk(oe, 6'h3f);
		@(posedge clk);
		rst <= 1'b0;
		acfg <= 8'h38;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			pc <= rows[i][6:2];
			wt(3);
			chk(ep, rows[i][1]);
			chk(ec, rows[i][0]);
		end
		chk(txp, 2'h3);
		chk(rxp, 2'h3);
		@(posedge clk);
		txw <= 2'h1;
		@(posedge clk);
		txw <= 2'h0;
		wt(1);
		chk(txp, 2'h2);
		wt(8);
		chk(txp, 2'h3);
		@(posedge clk);
		rxl <= 2'h1;
		wt(5);
		chk(rxp, 2'h1);
		@(posedge clk);
		rxl <= 2'h3;
		bell <= 2'h1;
		wt(4);
		chk(rxp, 2'h1);
		wt(4);
		chk(rxp, 2'h3);
		chk(rii, 2'h1);
		@(posedge clk);
		acfg <= 8'h00;
		wt(3);
		chk({txp, rxp}, 4'h0);
		chk({ep, ec}, 2'h0);
		@(posedge clk);
		dcfg <= 8'h39;
		irq <= 1'b1;
		drq <= 1'b1;
		core <= 11'h2b5;
		sv <= 8'h3c;
		acc <= '{rd: 1'b0, wr: 1'b1, addr: 3'h7, wdata: 8'h5a};
		@(posedge clk);
		acc <= '{rd: 1'b1, wr: 1'b0, addr: 3'h0, wdata: 8'h00};
		wt(1);
		chk(rd, 8'h3c);
		chk(rcc, 8'h5a);
		chk({fp, ep, ec, txp, rxp}, 16'h007f);
		chk({iro, dro}, 2'h0);
		chk(oe, 6'h00);
		chk(fo, core);
		@(posedge clk);
		acc <= '0;
		dcfg <= 8'h00;
		wt(2);
		chk({fp, iro, dro}, 3'h3);
		chk(oe, 6'h3f);
		@(posedge clk);
		acc <= '{rd: 1'b0, wr: 1'b1, addr: 3'h2, wdata: 8'h10};
		@(posedge clk);
		acc <= '{rd: 1'b0, wr: 1'b1, addr: 3'h4, wdata: 8'h02};
		@(posedge clk);
		acc <= '{rd: 1'b1, wr: 1'b0, addr: 3'h2, wdata: 8'h00};
		wt(1);
		chk(rd, 8'h10);
		chk(rsr, 8'h02);
		@(posedge clk);
		acc <= '0;
		rst <= 1'b1;
		wt(2);
		chk(doc, 8'h04);
		chk({fp, txp, rxp, rii}, 7'h00);
		@(posedge clk);
		rst <= 1'b0;
		wt(2);
		chk(doc, 8'h04);
		chk(oe, 6'h3f);
		chk(rii, 2'h1);
		final_report();
	end
endmodule
